//--- rtl/dbi_pkg.sv
// shared constants and types for the dma bus interface block
package dbi_pkg;
    localparam int NUM_CH = 4;
    localparam int CH_W = 2;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int NIB_W = 4;
    localparam int FIFO_DEPTH = 32;
    localparam int SYNC_STAGES = 2;
    localparam int CLK_PERIOD_NS = 8;

    // field positions within a transfer address
    localparam int LO_NIB_LSB = 0;
    localparam int UP_NIB_LSB = 4;
    localparam int UPPER_LSB = 8;
    localparam int ADDR_BIT_ZERO = 0;

    // reset values
    localparam logic REQ_POL_RESET = 1'b0;   // 0: request active high
    localparam logic ACK_POL_RESET = 1'b0;   // 0: acknowledge active low
    localparam logic STROBE_IDLE = 1'b1;     // active-low strobes at rest
    localparam logic [NIB_W-1:0] NIB_ZERO = 4'h0;
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 16'h0000;
    localparam logic [CH_W-1:0] CH_ZERO = 2'h0;

    // width-latch-enable levels during the address update state
    localparam logic WIDTH_IS_16 = 1'b0;
    localparam logic WIDTH_IS_8 = 1'b1;

    typedef enum logic [1:0] {
        DBI_XFER_VERIFY,
        DBI_XFER_WRITE,
        DBI_XFER_READ,
        DBI_XFER_MEM2MEM
    } dbi_xfer_t;

    typedef enum {
        DBI_ST_IDLE,
        DBI_ST_HOLD_WAIT,
        DBI_ST_ADDR_UPDATE,
        DBI_ST_S2,
        DBI_ST_S3,
        DBI_ST_S4
    } dbi_state_t;
endpackage

//--- rtl/dbi_stream_if.sv
// valid/ready word carrier between the block's own modules
`timescale 1ns/100ps
interface dbi_stream_if #(parameter int WIDTH = 16);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

//--- rtl/dbi_sync.sv
// two-stage synchroniser for asynchronous pin levels
`timescale 1ns/100ps
module dbi_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta_q <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

//--- rtl/dbi_fifo.sv
// transfer address fifo with valid/ready on both sides
`timescale 1ns/100ps
module dbi_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic ref_clk,
    input wire logic rst,
    dbi_stream_if.snk wr,
    dbi_stream_if.src rd
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam logic [PTR_W:0] CNT_FULL = (PTR_W+1)'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PTR_W-1:0] wptr_q;
    logic [PTR_W-1:0] rptr_q;
    logic [PTR_W:0] count_q;
    logic do_wr;
    logic do_rd;

    assign wr.ready = (count_q != CNT_FULL);
    assign rd.valid = (count_q != '0);
    assign rd.data = mem_q[rptr_q];
    assign do_wr = wr.valid && wr.ready;
    assign do_rd = rd.valid && rd.ready;

    always_ff @(posedge ref_clk) begin
        if (do_wr) begin
            mem_q[wptr_q] <= wr.data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wptr_q <= '0;
            rptr_q <= '0;
            count_q <= '0;
        end else begin
            if (do_wr) begin
                wptr_q <= (wptr_q == PTR_W'(DEPTH - 1)) ? '0 : wptr_q + 1'b1;
            end
            if (do_rd) begin
                rptr_q <= (rptr_q == PTR_W'(DEPTH - 1)) ? '0 : rptr_q + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count_q <= count_q + 1'b1;
            end else if (do_rd && !do_wr) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule

//--- rtl/dbi_top.sv
// bus interface signalling of a four-channel dma controller
`timescale 1ns/100ps
module dbi_top
    import dbi_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    // configuration
    input wire logic [NUM_CH-1:0] channel_request,
    input wire logic [NUM_CH-1:0] channel_mask,
    input wire logic [NUM_CH-1:0] software_request,
    input wire logic polarity_write,
    input wire logic request_active_low,
    input wire logic acknowledge_active_high,
    input wire logic mode16_enable,
    input wire logic [NUM_CH-1:0] channel_is_16bit,
    input wire dbi_xfer_t transfer_type,
    input wire logic block_mode,
    // transfer address source
    input wire logic addr_valid,
    output logic addr_ready,
    input wire logic [ADDR_W-1:0] addr_data,
    // host handshake
    output logic hold_request,
    input wire logic hold_acknowledge,
    output logic [NUM_CH-1:0] channel_acknowledge,
    // address pins
    input wire logic [NIB_W-1:0] low_address_nibble_in,
    output logic [NIB_W-1:0] low_address_nibble_out,
    output logic low_address_nibble_oe,
    output logic [NIB_W-1:0] upper_address_nibble,
    output logic upper_address_nibble_oe,
    output logic address_enable_out,
    output logic upper_address_strobe,
    // data pins
    input wire logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe,
    // strobes
    output logic memory_read_strobe_n,
    output logic memory_read_strobe_oe,
    output logic memory_write_strobe_n,
    output logic memory_write_strobe_oe,
    input wire logic io_read_strobe_n_in,
    output logic io_read_strobe_n_out,
    output logic io_read_strobe_oe,
    input wire logic io_write_strobe_n_in,
    output logic io_write_strobe_n_out,
    output logic io_write_strobe_oe,
    output logic width_latch_enable,
    output logic width_latch_enable_oe,
    // idle register access seen on the pins
    output logic [NIB_W-1:0] register_select,
    output logic register_read,
    output logic register_write
);
    dbi_state_t state_q;
    dbi_xfer_t xfer_q;
    logic write_half_q;
    logic [CH_W-1:0] chan_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] upper_q;
    logic upper_vld_q;
    logic [DATA_W-1:0] copy_byte_q;
    logic hrq_q;
    logic req_pol_q;
    logic ack_pol_q;

    logic [NUM_CH-1:0] req_sync;
    logic [NIB_W-1:0] nib_sync;
    logic [1:0] io_sync;
    logic [DATA_W-1:0] data_sync;
    logic [NUM_CH-1:0] pending;
    logic [CH_W-1:0] winner;
    logic in_service;
    logic word_addr;
    logic load_addr;
    logic next_strobe;
    logic more;
    logic [ADDR_W-1:0] fifo_head;
    logic fifo_valid;

    dbi_stream_if #(.WIDTH(ADDR_W)) push_if ();
    dbi_stream_if #(.WIDTH(ADDR_W)) pop_if ();

    assign push_if.valid = addr_valid;
    assign push_if.data = addr_data;
    assign addr_ready = push_if.ready;
    assign fifo_head = pop_if.data;
    assign fifo_valid = pop_if.valid;
    assign pop_if.ready = load_addr;

    dbi_fifo #(.WIDTH(ADDR_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .wr(push_if),
        .rd(pop_if)
    );

    dbi_sync #(.WIDTH(NUM_CH), .RST_VAL('0)) u_req_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .async_in(channel_request),
        .sync_out(req_sync)
    );

    dbi_sync #(.WIDTH(NIB_W), .RST_VAL(NIB_ZERO)) u_nib_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .async_in(low_address_nibble_in),
        .sync_out(nib_sync)
    );

    dbi_sync #(.WIDTH(2), .RST_VAL({STROBE_IDLE, STROBE_IDLE})) u_io_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .async_in({io_write_strobe_n_in, io_read_strobe_n_in}),
        .sync_out(io_sync)
    );

    dbi_sync #(.WIDTH(DATA_W), .RST_VAL(BYTE_ZERO)) u_data_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .async_in(data_in),
        .sync_out(data_sync)
    );

    // lowest channel number wins among pending requests
    function automatic logic [CH_W-1:0] pick_channel(input logic [NUM_CH-1:0] p);
        logic [CH_W-1:0] c;
        c = CH_ZERO;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (p[i]) begin
                c = CH_W'(i);
            end
        end
        return c;
    endfunction

    // does the next address need a fresh upper-byte strobe
    function automatic logic need_strobe(input logic [ADDR_W-1:0] a, input logic blk,
                                         input logic vld, input logic [DATA_W-1:0] last);
        return !(blk && vld && (a[UPPER_LSB +: DATA_W] == last));
    endfunction

    always_comb begin
        pending = ((req_pol_q ? ~req_sync : req_sync) & ~channel_mask) | software_request;
    end
    assign winner = pick_channel(pending);
    assign in_service = (state_q == DBI_ST_ADDR_UPDATE) || (state_q == DBI_ST_S2) ||
                        (state_q == DBI_ST_S3) || (state_q == DBI_ST_S4);
    assign word_addr = mode16_enable && channel_is_16bit[chan_q];
    assign next_strobe = need_strobe(fifo_head, block_mode, upper_vld_q, upper_q);
    // another transfer only while the peripheral keeps asking
    assign more = block_mode && pending[chan_q] && fifo_valid;

    // address words are taken where a transfer or a half begins
    always_comb begin
        load_addr = 1'b0;
        case (state_q)
            DBI_ST_HOLD_WAIT: begin
                load_addr = hold_acknowledge && fifo_valid;
            end
            DBI_ST_S4: begin
                if (xfer_q == DBI_XFER_MEM2MEM && !write_half_q) begin
                    load_addr = fifo_valid;
                end else begin
                    load_addr = more;
                end
            end
            default: begin
                load_addr = 1'b0;
            end
        endcase
    end

    // polarity settings, defaulting at reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            req_pol_q <= REQ_POL_RESET;
            ack_pol_q <= ACK_POL_RESET;
        end else if (polarity_write && state_q == DBI_ST_IDLE) begin
            req_pol_q <= request_active_low;
            ack_pol_q <= acknowledge_active_high;
        end
    end

    // service sequencer
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= DBI_ST_IDLE;
            write_half_q <= 1'b0;
            chan_q <= CH_ZERO;
            xfer_q <= DBI_XFER_VERIFY;
        end else begin
            case (state_q)
                DBI_ST_IDLE: begin
                    if (|pending && fifo_valid) begin
                        state_q <= DBI_ST_HOLD_WAIT;
                        chan_q <= winner;
                        xfer_q <= transfer_type;
                        write_half_q <= 1'b0;
                    end
                end
                DBI_ST_HOLD_WAIT: begin
                    // acknowledge in the same cycle as the request leaves one wait state
                    if (load_addr) begin
                        state_q <= DBI_ST_ADDR_UPDATE;
                    end
                end
                DBI_ST_ADDR_UPDATE: begin
                    state_q <= DBI_ST_S2;
                end
                DBI_ST_S2: begin
                    state_q <= DBI_ST_S3;
                end
                DBI_ST_S3: begin
                    state_q <= DBI_ST_S4;
                end
                DBI_ST_S4: begin
                    if (xfer_q == DBI_XFER_MEM2MEM && !write_half_q) begin
                        // missing write address stretches the read half
                        if (load_addr) begin
                            write_half_q <= 1'b1;
                            state_q <= next_strobe ? DBI_ST_ADDR_UPDATE : DBI_ST_S2;
                        end
                    end else if (load_addr) begin
                        write_half_q <= 1'b0;
                        state_q <= next_strobe ? DBI_ST_ADDR_UPDATE : DBI_ST_S2;
                    end else begin
                        state_q <= DBI_ST_IDLE;
                    end
                end
                default: begin
                    state_q <= DBI_ST_IDLE;
                end
            endcase
        end
    end

    // address and upper byte tracking
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            addr_q <= ADDR_ZERO;
            upper_q <= BYTE_ZERO;
            upper_vld_q <= 1'b0;
        end else begin
            if (load_addr) begin
                addr_q <= fifo_head;
            end
            if (state_q == DBI_ST_ADDR_UPDATE) begin
                upper_q <= addr_q[UPPER_LSB +: DATA_W];
                upper_vld_q <= 1'b1;
            end else if (state_q == DBI_ST_IDLE) begin
                upper_vld_q <= 1'b0;
            end
        end
    end

    // read data byte held between the halves of a memory copy
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            copy_byte_q <= BYTE_ZERO;
        end else if (state_q == DBI_ST_S4 && xfer_q == DBI_XFER_MEM2MEM && !write_half_q) begin
            copy_byte_q <= data_sync;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hrq_q <= 1'b0;
        end else begin
            hrq_q <= (state_q == DBI_ST_IDLE) ? (|pending && fifo_valid) :
                     !(state_q == DBI_ST_S4 && !load_addr &&
                       !(xfer_q == DBI_XFER_MEM2MEM && !write_half_q));
        end
    end
    assign hold_request = hrq_q;

    // per-channel acknowledge, inactive level follows polarity
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            channel_acknowledge[i] = (in_service && chan_q == CH_W'(i)) ? ack_pol_q
                                                                         : !ack_pol_q;
        end
    end

    // address pins
    always_comb begin
        low_address_nibble_out = addr_q[LO_NIB_LSB +: NIB_W];
        if (word_addr) begin
            low_address_nibble_out[ADDR_BIT_ZERO] = 1'b0;
        end
    end
    assign low_address_nibble_oe = in_service;
    assign upper_address_nibble = addr_q[UP_NIB_LSB +: NIB_W];
    assign upper_address_nibble_oe = in_service;
    assign address_enable_out = in_service;
    // one full cycle wide, so the latch closes on the next rising edge
    assign upper_address_strobe = (state_q == DBI_ST_ADDR_UPDATE);

    // data pins: upper address byte, then copy data in the write half
    always_comb begin
        data_oe = 1'b0;
        data_out = BYTE_ZERO;
        if (state_q == DBI_ST_ADDR_UPDATE) begin
            data_oe = 1'b1;
            data_out = addr_q[UPPER_LSB +: DATA_W];
        end else if (in_service && xfer_q == DBI_XFER_MEM2MEM && write_half_q) begin
            data_oe = 1'b1;
            data_out = copy_byte_q;
        end
    end

    // strobes; read side opens one state before write side
    always_comb begin
        logic rd_phase;
        logic wr_phase;
        rd_phase = (state_q == DBI_ST_S2) || (state_q == DBI_ST_S3) || (state_q == DBI_ST_S4);
        wr_phase = (state_q == DBI_ST_S3) || (state_q == DBI_ST_S4);
        memory_read_strobe_n = !(rd_phase && (xfer_q == DBI_XFER_READ ||
                               (xfer_q == DBI_XFER_MEM2MEM && !write_half_q)));
        memory_write_strobe_n = !(wr_phase && (xfer_q == DBI_XFER_WRITE ||
                                (xfer_q == DBI_XFER_MEM2MEM && write_half_q)));
        io_read_strobe_n_out = !(rd_phase && xfer_q == DBI_XFER_WRITE);
        io_write_strobe_n_out = !(wr_phase && xfer_q == DBI_XFER_READ);
    end
    assign memory_read_strobe_oe = in_service;
    assign memory_write_strobe_oe = in_service;
    assign io_read_strobe_oe = in_service;
    assign io_write_strobe_oe = in_service;

    // width / latch enable pin
    always_comb begin
        width_latch_enable_oe = mode16_enable && in_service;
        width_latch_enable = 1'b0;
        if (state_q == DBI_ST_ADDR_UPDATE) begin
            width_latch_enable = channel_is_16bit[chan_q] ? WIDTH_IS_16 : WIDTH_IS_8;
        end else if (xfer_q == DBI_XFER_MEM2MEM) begin
            width_latch_enable = write_half_q ? (state_q != DBI_ST_IDLE)
                                              : (state_q == DBI_ST_S3 ||
                                                 state_q == DBI_ST_S4);
        end
    end

    // idle register access decoded from the pins
    assign register_select = nib_sync;
    assign register_read = (state_q == DBI_ST_IDLE) && !io_sync[0];
    assign register_write = (state_q == DBI_ST_IDLE) && !io_sync[1];
endmodule

//--- test/dbi_host_model.sv
// host processor model answering hold with acknowledge after a set lag
`timescale 1ns/100ps
module dbi_host_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [3:0] lag,
    input wire logic hold_request,
    output logic hold_acknowledge
);
    logic [3:0] cnt_q;
    logic ack_q;
    // lag zero stands for hold tied straight back to acknowledge
    assign hold_acknowledge = (lag == 4'h0) ? hold_request : ack_q;
    always_ff @(posedge ref_clk) begin
        if (rst || !hold_request) begin
            cnt_q <= 4'h0;
            ack_q <= 1'b0;
        end else if (cnt_q == lag) begin
            ack_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule

//--- test/dbi_top_monitor.sv
// concurrent checks on the bus interface pins
`timescale 1ns/100ps
module dbi_top_monitor
    import dbi_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hold_request,
    input wire logic hold_acknowledge,
    input wire logic [NUM_CH-1:0] channel_acknowledge,
    input wire logic low_address_nibble_oe,
    input wire logic upper_address_nibble_oe,
    input wire logic address_enable_out,
    input wire logic upper_address_strobe,
    input wire logic data_oe,
    input wire logic memory_read_strobe_n,
    input wire logic memory_read_strobe_oe,
    input wire logic memory_write_strobe_n,
    input wire logic memory_write_strobe_oe,
    input wire logic io_read_strobe_oe,
    input wire logic io_write_strobe_oe,
    input wire logic width_latch_enable_oe,
    input wire logic mode16_enable
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_grant;
        $rose(address_enable_out) |-> $past(hold_acknowledge) && hold_request;
    endproperty
    a_grant: assert property (p_grant) else $error("bus driven without grant");
    property p_loop;
        $rose(hold_request) && hold_acknowledge |=> address_enable_out;
    endproperty
    a_loop: assert property (p_loop) else $error("looped hold not one wait");
    property p_release;
        !hold_request |-> !(upper_address_nibble_oe || low_address_nibble_oe || data_oe
            || memory_read_strobe_oe || memory_write_strobe_oe);
    endproperty
    a_release: assert property (p_release) else $error("bus outputs not released");
    property p_io;
        !hold_request |-> !io_read_strobe_oe && !io_write_strobe_oe;
    endproperty
    a_io: assert property (p_io) else $error("io strobes driven while idle");
    property p_aen;
        address_enable_out |-> upper_address_nibble_oe && low_address_nibble_oe
            && memory_read_strobe_oe;
    endproperty
    a_aen: assert property (p_aen) else $error("address pins off in transfer");
    property p_stb;
        upper_address_strobe |-> address_enable_out && data_oe ##1 !upper_address_strobe;
    endproperty
    a_stb: assert property (p_stb) else $error("address strobe malformed");
    property p_rw;
        memory_read_strobe_oe |-> memory_read_strobe_n || memory_write_strobe_n;
    endproperty
    a_rw: assert property (p_rw) else $error("read and write strobes overlap");
    property p_w16;
        !mode16_enable && !$past(mode16_enable) |-> !width_latch_enable_oe;
    endproperty
    a_w16: assert property (p_w16) else $error("width latch driven in byte mode");
    property p_ack;
        address_enable_out |-> $onehot(channel_acknowledge) || $onehot(~channel_acknowledge);
    endproperty
    a_ack: assert property (p_ack) else $error("acknowledge not single");
    c_stb: cover property (upper_address_strobe);
    c_wr: cover property (memory_write_strobe_oe && !memory_write_strobe_n);
    c_w16: cover property (width_latch_enable_oe);
endmodule
bind dbi_top dbi_top_monitor dbi_top_monitor_inst (.ref_clk, .rst, .hold_request,
    .hold_acknowledge, .channel_acknowledge, .low_address_nibble_oe, .upper_address_nibble_oe,
    .address_enable_out, .upper_address_strobe, .data_oe, .memory_read_strobe_n,
    .memory_read_strobe_oe, .memory_write_strobe_n, .memory_write_strobe_oe,
    .io_read_strobe_oe, .io_write_strobe_oe, .width_latch_enable_oe, .mode16_enable);

//--- test/dbi_top_bench.sv
// self-checking bench driving transfers through the bus interface block
`timescale 1ns/100ps
module dbi_top_bench;
    import dbi_pkg::*;
    logic ref_clk, rst, polarity_write, request_active_low, acknowledge_active_high, io_wr_n;
    logic mode16_enable, block_mode, addr_valid, addr_ready, hold_request, hold_acknowledge;
    logic [NUM_CH-1:0] channel_request, channel_mask, software_request, channel_is_16bit;
    logic [NUM_CH-1:0] channel_acknowledge, ack_seen;
    dbi_xfer_t transfer_type;
    logic [ADDR_W-1:0] addr_data;
    logic [NIB_W-1:0] low_address_nibble_in, low_address_nibble_out, upper_address_nibble;
    logic [NIB_W-1:0] register_select, lo_seen, up_seen;
    logic low_address_nibble_oe, upper_address_nibble_oe, address_enable_out;
    logic upper_address_strobe, data_oe, memory_read_strobe_n, memory_read_strobe_oe;
    logic memory_write_strobe_n, memory_write_strobe_oe, io_read_strobe_n_out;
    logic io_read_strobe_oe, io_write_strobe_n_out, io_write_strobe_oe, width_latch_enable;
    logic width_latch_enable_oe, register_read, register_write, wle_seen;
    logic [DATA_W-1:0] data_out, hi_seen;
    logic [3:0] lag;
    int errors, cmp_count, cycles, n_stb, n_rd, n_wr;

    dbi_top dbi_top_inst (.ref_clk, .rst, .channel_request, .channel_mask, .software_request,
        .polarity_write, .request_active_low, .acknowledge_active_high, .mode16_enable,
        .channel_is_16bit, .transfer_type, .block_mode, .addr_valid, .addr_ready, .addr_data,
        .hold_request, .hold_acknowledge, .channel_acknowledge, .low_address_nibble_in,
        .low_address_nibble_out, .low_address_nibble_oe, .upper_address_nibble,
        .upper_address_nibble_oe, .address_enable_out, .upper_address_strobe,
        .data_in(BYTE_ZERO), .data_out, .data_oe, .memory_read_strobe_n, .memory_read_strobe_oe,
        .memory_write_strobe_n, .memory_write_strobe_oe, .io_read_strobe_n_in(STROBE_IDLE),
        .io_read_strobe_n_out, .io_read_strobe_oe, .io_write_strobe_n_in(io_wr_n),
        .io_write_strobe_n_out, .io_write_strobe_oe, .width_latch_enable,
        .width_latch_enable_oe, .register_select, .register_read, .register_write);
    dbi_host_model dbi_host_model_inst (.ref_clk, .rst, .lag, .hold_request, .hold_acknowledge);

    initial begin
        ref_clk = 1'b0;
        forever #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
    end

    // sampled at the falling edge so registered outputs have settled
    always @(negedge ref_clk) begin
        if (upper_address_strobe === 1'b1) begin
            n_stb++;
            lo_seen = low_address_nibble_out;
            up_seen = upper_address_nibble;
            hi_seen = data_out;
            wle_seen = width_latch_enable;
            ack_seen = channel_acknowledge;
        end
        if (memory_read_strobe_oe && !memory_read_strobe_n) n_rd++;
        if (memory_write_strobe_oe && !memory_write_strobe_n) n_wr++;
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            results();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic push(input logic [ADDR_W-1:0] a);
        int n;
        n = 0;
        @(posedge ref_clk);
        addr_valid <= 1'b1;
        addr_data <= a;
        @(negedge ref_clk);
        while (addr_ready !== 1'b1 && n < 50) begin
            @(negedge ref_clk);
            n++;
        end
        @(posedge ref_clk);
        addr_valid <= 1'b0;
    endtask

    // request stays up until the service is over, well past the acknowledge
    task automatic xfer(input int ch, input dbi_xfer_t ty, input logic sw);
        int n;
        n = 0;
        {n_stb, n_rd, n_wr} = '0;
        @(posedge ref_clk);
        transfer_type <= ty;
        if (sw) software_request[ch] <= 1'b1;
        else channel_request[ch] <= 1'b1;
        @(negedge ref_clk);
        while (hold_request !== 1'b1 && n < 40) begin
            @(negedge ref_clk);
            n++;
        end
        while (hold_request !== 1'b0 && n < 2000) begin
            @(negedge ref_clk);
            n++;
        end
        @(posedge ref_clk);
        channel_request <= '0;
        software_request <= '0;
        check("service end", n < 2000, 1);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        {rst, io_wr_n, errors, cmp_count, cycles} = '1;
        {errors, cmp_count, cycles} = '0;
        {channel_request, channel_mask, software_request, channel_is_16bit} = '0;
        {polarity_write, request_active_low, acknowledge_active_high} = '0;
        {mode16_enable, block_mode, addr_valid, addr_data, low_address_nibble_in} = '0;
        transfer_type = DBI_XFER_READ;
        lag = 4'h0;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        check("hold", hold_request, 0);
        check("ack", channel_acknowledge, 4'hF);
        check("up oe", upper_address_nibble_oe, 0);
        @(posedge ref_clk);
        low_address_nibble_in <= 4'hA;
        io_wr_n <= 1'b0;
        repeat (5) @(negedge ref_clk);
        check("select", register_select, 4'hA);
        check("reg access", {register_read, register_write}, 2'h1);
        $display("test reset and select done");
        for (int i = 0; i < FIFO_DEPTH; i++) push(16'h5500 + 16'(i));
        @(negedge ref_clk);
        check("full", addr_ready, 0);
        @(posedge ref_clk);
        io_wr_n <= 1'b1;
        block_mode <= 1'b1;
        lag <= 4'h3;
        xfer(0, DBI_XFER_READ, 0);
        check("strobes", n_stb, 1);
        check("reads", n_rd, 3 * FIFO_DEPTH);
        check("upper byte", hi_seen, 8'h55);
        check("empty", addr_ready, 1);
        block_mode <= 1'b0;
        lag <= 4'h0;
        $display("test block fill and drain done");
        push(16'hA7C3);
        xfer(1, DBI_XFER_WRITE, 0);
        check("writes", n_wr, 2);
        check("no read", n_rd, 0);
        check("low nibble", lo_seen, 4'h3);
        check("up nibble", up_seen, 4'hC);
        check("byte", hi_seen, 8'hA7);
        check("ack1", ack_seen, 4'hD);
        push(16'h1230);
        push(16'h1240);
        xfer(2, DBI_XFER_MEM2MEM, 1);
        check("copy rd", n_rd, 3);
        check("copy wr", n_wr, 2);
        $display("test write and copy done");
        mode16_enable <= 1'b1;
        channel_is_16bit <= 4'h8;
        push(16'h00F7);
        xfer(3, DBI_XFER_READ, 0);
        check("even", lo_seen, 4'h6);
        check("wle16", wle_seen, WIDTH_IS_16);
        push(16'h00F7);
        xfer(2, DBI_XFER_READ, 0);
        check("odd", lo_seen, 4'h7);
        check("wle8", wle_seen, WIDTH_IS_8);
        mode16_enable <= 1'b0;
        $display("test wide mode done");
        channel_mask <= 4'h1;
        push(16'h0101);
        channel_request <= 4'h1;
        repeat (10) @(negedge ref_clk);
        check("masked", hold_request, 0);
        @(posedge ref_clk);
        channel_mask <= 4'h0;
        xfer(0, DBI_XFER_READ, 0);
        check("unmasked", n_rd, 3);
        @(posedge ref_clk);
        polarity_write <= 1'b1;
        acknowledge_active_high <= 1'b1;
        @(posedge ref_clk);
        polarity_write <= 1'b0;
        @(negedge ref_clk);
        check("ack high idle", channel_acknowledge, 4'h0);
        push(16'h0202);
        xfer(1, DBI_XFER_READ, 0);
        check("ack high", ack_seen, 4'h2);
        $display("test mask and polarity done");
        results();
    end
endmodule
